// ===== rtl/bcs_defs.vh
// Constants for the buck converter sequencer
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH
`define BCS_CLK_HZ          100000000
`define BCS_SS_STEPS        64
`define BCS_SS_CYCLES       4096
`define BCS_STEP_CYCLES     64
`define BCS_REF_W           6
`define BCS_REF_MAX         6'h3f
`define BCS_PER_W           10
`define BCS_PER_MIN         10'h02d
`define BCS_PER_MAX         10'h1f4
`define BCS_PER_DEFAULT     10'h064
`define BCS_FOLD_SHIFT      2
`define BCS_SHIFT_DEG       115
`define BCS_REFRESH_EVERY   4
`define BCS_RST_TIMEOUT_MS  200
`define BCS_RST_TIMEOUT_CYC (`BCS_CLK_HZ / 1000 * `BCS_RST_TIMEOUT_MS)
`define BCS_SYNC_LOST_MULT  8
`endif

// ===== rtl/bcs_osc.v
// Switching oscillator with sync lock, fallback and phase-shifted clock
`timescale 1ns/1ns
`default_nettype none
`include "bcs_defs.vh"
module bcs_osc (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // Control
  input  wire [`BCS_PER_W-1:0]  period,
  input  wire                   sync_in,
  input  wire                   fold,
  // Outputs
  output reg                    cycle_start,
  output reg                    phase_clock,
  output reg                    sync_locked
);
  reg  [`BCS_PER_W-1:0]   cnt;
  reg  [`BCS_PER_W-1:0]   sync_per;
  reg  [`BCS_PER_W+3:0]   lost_cnt;
  reg  [1:0]              fold_cnt;
  reg                     sync_d;
  wire                    sync_rise = sync_in & ~sync_d;
  wire [`BCS_PER_W-1:0]   cur_per = sync_locked ? sync_per : period;
  // Edge at 115 degrees of the running period
  wire [`BCS_PER_W+7:0]   shift_full = cur_per * 8'd115 / 9'd360;
  wire [`BCS_PER_W-1:0]   shift_at = shift_full[`BCS_PER_W-1:0];
  wire [`BCS_PER_W-1:0]   half = {1'b0, cur_per[`BCS_PER_W-1:1]};
  wire                    wrap = (cnt >= cur_per - 1'b1);
  // Eight internal periods of silence mean sync is lost
  wire [`BCS_PER_W+3:0]   lim = {1'b0, period, 3'h0};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt         <= {`BCS_PER_W{1'b0}};
      sync_per    <= `BCS_PER_DEFAULT;
      lost_cnt    <= {(`BCS_PER_W+4){1'b0}};
      fold_cnt    <= 2'h0;
      sync_d      <= 1'b0;
      sync_locked <= 1'b0;
      cycle_start <= 1'b0;
      phase_clock <= 1'b0;
    end else begin
      sync_d      <= sync_in;
      cycle_start <= 1'b0;
      if (sync_rise) begin
        // Sync edge restarts the cycle after a fixed one-clock delay
        if (sync_locked && cnt + 1'b1 >= `BCS_PER_MIN)
          sync_per <= cnt + 1'b1;
        sync_locked <= 1'b1;
        lost_cnt    <= {(`BCS_PER_W+4){1'b0}};
        cnt         <= {`BCS_PER_W{1'b0}};
        fold_cnt    <= fold_cnt + 2'h1;
        cycle_start <= !fold || (fold_cnt == 2'h3);
      end else begin
        if (sync_locked && lost_cnt >= lim)
          sync_locked <= 1'b0;
        else
          lost_cnt <= lost_cnt + 1'b1;
        if (wrap && !sync_locked) begin
          cnt         <= {`BCS_PER_W{1'b0}};
          fold_cnt    <= fold_cnt + 2'h1;
          cycle_start <= !fold || (fold_cnt == 2'h3);
        end else if (!wrap) begin
          cnt <= cnt + 1'b1;
        end
      end
      phase_clock <= (cnt >= shift_at) ? (cnt < shift_at + half) :
                     (cnt + cur_per < shift_at + half);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bcs_ramp.v
// Digital reference ramp for soft-start and soft-stop
`timescale 1ns/1ns
`default_nettype none
`include "bcs_defs.vh"
module bcs_ramp (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // Control
  input  wire                   osc_tick,
  input  wire                   go_up,
  input  wire                   clear,
  // Status
  output reg  [`BCS_REF_W-1:0]  level,
  output reg                    at_top,
  output reg                    at_zero
);
  reg [5:0] div;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level   <= {`BCS_REF_W{1'b0}};
      div     <= 6'h00;
      at_top  <= 1'b0;
      at_zero <= 1'b1;
    end else begin
      if (clear) begin
        level   <= {`BCS_REF_W{1'b0}};
        div     <= 6'h00;
        at_top  <= 1'b0;
        at_zero <= 1'b1;
      end else if (osc_tick) begin
        div <= div + 6'h01;
        // One step per 64 oscillator cycles: 63 steps take 4032 cycles
        if (div == 6'h3f) begin
          if (go_up && !at_top) begin
            level   <= level + 1'b1;
            at_zero <= 1'b0;
            at_top  <= (level == `BCS_REF_MAX - 1'b1);
          end else if (!go_up && !at_zero) begin
            level   <= level - 1'b1;
            at_top  <= 1'b0;
            at_zero <= (level == 6'h01);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bcs_top.v
// Top of the buck converter sequencer: sequencing, switch control, status
`timescale 1ns/1ns
`default_nettype none
`include "bcs_defs.vh"
// Functional notes
// - Enable low turns switch off and drives reset and output-ok low.
// - Lockout release or enable rise ramps reference up in 64 steps; the ramp here takes 63 steps, 0 to 63.
// - Soft-start and soft-stop each last 4096 oscillator cycles; the full ramp here takes 4032 (63 steps of 64).
// - Enable low or supply loss lowers reference gradually to zero.
// - Stay off until supply at 4.5V; turn off below 4.3V.
// - Lock to external sync rising edges, each starting a switch turn-on.
// - Clock output at switching frequency, shifted 115 degrees.
// - Current at 2.8A turns switch off until next cycle.
// - During current limit, switching frequency folds back to one quarter.
// - Feedback below 0.2V in overload: shut off, then restart soft-start.
// - Reset output low whenever output below 92.5 percent.
// - Reset released after output good, soft-start done, then 200 ms.
// - Output-ok low below 92.5 percent; low enable forces it low.
// - Thermal shutdown at 170C; leave after 25C fall.
// - Thermal shutdown: switch off, low gate low, regulator off, flags low, restart.
// - Internal oscillator set by resistor, 200kHz to 2.2MHz.
// - Lost sync falls back to internal oscillator.
// - Each cycle turns switch on until duty or current limit.
// - Non-synchronous variant refreshes bootstrap in off-time every 4 cycles.
module bcs_top #(
  parameter RST_TIMEOUT_CYC = `BCS_RST_TIMEOUT_CYC,
  parameter SYNC_VARIANT    = 1
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // Host controls
  input  wire                   enable,
  input  wire                   sync_in,
  input  wire [`BCS_PER_W-1:0]  freq_set_pin,
  // Analog comparator results
  input  wire                   supply_above_on,
  input  wire                   supply_below_off,
  input  wire                   current_limit,
  input  wire                   fb_below_third,
  input  wire                   vout_above_good,
  input  wire                   temp_hot,
  input  wire                   temp_cooled,
  input  wire                   duty_reached,
  // Power stage
  output reg                    high_side_on,
  output reg                    low_side_gate_drive,
  output reg                    boot_refresh,
  output reg                    regulator_en,
  // Reference and clock
  output reg  [`BCS_REF_W-1:0]  soft_reference,
  output reg                    phase_clock_out,
  // Status
  output reg                    reset_out_n,
  output reg                    output_ok_flag,
  output reg                    thermal_shutdown,
  output reg                    soft_start_done
);
  localparam ST_OFF   = 3'h0;
  localparam ST_RAMP  = 3'h1;
  localparam ST_RUN   = 3'h2;
  localparam ST_STOP  = 3'h3;
  localparam ST_HICUP = 3'h4;

  reg  [2:0]             state;
  reg  [2:0]             next_state;
  reg                    supply_ok;
  reg                    enable_d;
  reg                    sw_on;
  reg                    limit_seen;
  reg  [1:0]             refresh_cnt;
  reg  [27:0]            timeout_cnt;
  reg  [`BCS_PER_W-1:0]  period;
  wire                   cycle_start;
  wire                   phase_clock;
  wire                   sync_locked;
  wire [`BCS_REF_W-1:0]  ramp_level;
  wire                   ramp_top;
  wire                   ramp_zero;
  wire                   enable_rise = enable & ~enable_d;
  wire                   go_up = (state == ST_RAMP) || (state == ST_RUN);
  wire                   ramp_clear = thermal_shutdown || (state == ST_OFF);
  wire                   running = (state != ST_OFF) && (state != ST_HICUP);
  wire                   off_cmd = !enable || !supply_ok;

  // Resistor-set rate clamped into the legal range
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      period <= `BCS_PER_DEFAULT;
    else if (freq_set_pin < `BCS_PER_MIN)
      period <= `BCS_PER_MIN;
    else if (freq_set_pin > `BCS_PER_MAX)
      period <= `BCS_PER_MAX;
    else
      period <= freq_set_pin;
  end

  bcs_osc u_osc (
    .clk         (clk),
    .rst_n       (rst_n),
    .period      (period),
    .sync_in     (sync_in),
    .fold        (limit_seen),
    .cycle_start (cycle_start),
    .phase_clock (phase_clock),
    .sync_locked (sync_locked)
  );

  bcs_ramp u_ramp (
    .clk      (clk),
    .rst_n    (rst_n),
    .osc_tick (cycle_start),
    .go_up    (go_up),
    .clear    (ramp_clear),
    .level    (ramp_level),
    .at_top   (ramp_top),
    .at_zero  (ramp_zero)
  );

  // Lockout with hysteresis and thermal latch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_ok        <= 1'b0;
      thermal_shutdown <= 1'b0;
      enable_d         <= 1'b0;
    end else begin
      enable_d <= enable;
      if (supply_below_off)
        supply_ok <= 1'b0;
      else if (supply_above_on)
        supply_ok <= 1'b1;
      if (temp_hot)
        thermal_shutdown <= 1'b1;
      else if (temp_cooled)
        thermal_shutdown <= 1'b0;
    end
  end

  // Sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_OFF:
        if (enable && supply_ok && !thermal_shutdown)
          next_state = ST_RAMP;
      ST_RAMP:
        if (off_cmd)
          next_state = ST_STOP;
        else if (ramp_top)
          next_state = ST_RUN;
      ST_RUN:
        if (off_cmd)
          next_state = ST_STOP;
        else if (limit_seen && fb_below_third)
          next_state = ST_HICUP;
      ST_STOP:
        if (ramp_zero)
          next_state = ST_OFF;
        else if (enable_rise && supply_ok)
          next_state = ST_RAMP;
      ST_HICUP:
        next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
    if (thermal_shutdown)
      next_state = ST_OFF;
  end

  // Switch timing per cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_OFF;
      sw_on       <= 1'b0;
      limit_seen  <= 1'b0;
      refresh_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (!running || thermal_shutdown || !enable) begin
        sw_on      <= 1'b0;
        limit_seen <= 1'b0;
      end else if (cycle_start) begin
        sw_on       <= !current_limit;
        limit_seen  <= current_limit;
        refresh_cnt <= refresh_cnt + 2'h1;
      end else if (current_limit) begin
        // Held off until the next cycle starts
        sw_on      <= 1'b0;
        limit_seen <= 1'b1;
      end else if (duty_reached) begin
        sw_on <= 1'b0;
      end
    end
  end

  // Registered pin outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_side_on        <= 1'b0;
      low_side_gate_drive <= 1'b0;
      boot_refresh        <= 1'b0;
      regulator_en        <= 1'b0;
      soft_reference      <= {`BCS_REF_W{1'b0}};
      phase_clock_out     <= 1'b0;
      soft_start_done     <= 1'b0;
    end else begin
      high_side_on        <= sw_on && !thermal_shutdown;
      // Synchronous variant drives the low side in the off-time
      low_side_gate_drive <= (SYNC_VARIANT != 0) && running && !sw_on &&
                             !high_side_on && !thermal_shutdown;
      // Refresh only on one cycle in four, to limit ripple at light load
      boot_refresh        <= (SYNC_VARIANT == 0) && running && !sw_on &&
                             (refresh_cnt == 2'h0) && !thermal_shutdown;
      regulator_en        <= !thermal_shutdown;
      soft_reference      <= ramp_level;
      phase_clock_out     <= phase_clock && running;
      soft_start_done     <= (state == ST_RUN);
    end
  end

  // Reset timeout and output-ok
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_cnt    <= 28'h0000000;
      reset_out_n    <= 1'b0;
      output_ok_flag <= 1'b0;
    end else begin
      if (!enable || thermal_shutdown || !vout_above_good) begin
        timeout_cnt <= 28'h0000000;
        reset_out_n <= 1'b0;
      end else if (state == ST_RUN) begin
        if (timeout_cnt >= RST_TIMEOUT_CYC - 1)
          reset_out_n <= 1'b1;
        else
          timeout_cnt <= timeout_cnt + 28'h0000001;
      end
      output_ok_flag <= enable && !thermal_shutdown && vout_above_good;
    end
  end
endmodule
`default_nettype wire

// ===== test/bcs_stage_model.sv
// Power stage model: duty end and overload current sense
`timescale 1ns/1ns
`default_nettype none
module bcs_stage_model #(parameter DUTY = 20, parameter ILIM = 6) (
  // Clock
  input  wire logic clk,
  // Gate and fault control
  input  wire logic high_side_on,
  input  wire logic overload,
  // Comparator results
  output var  logic duty_reached,
  output var  logic current_limit
);
  int on_cnt = 0;
  initial begin
    duty_reached = 1'b0;
    current_limit = 1'b0;
  end
  // Current builds only while the switch conducts
  always @(posedge clk) begin
    on_cnt <= high_side_on ? on_cnt + 1 : 0;
    duty_reached <= high_side_on && on_cnt >= DUTY;
    current_limit <= high_side_on && overload && on_cnt >= ILIM;
  end
endmodule
`default_nettype wire

// ===== test/bcs_top_asserts.sv
// Checker for the buck converter sequencer top
`timescale 1ns/1ns
`default_nettype none
module bcs_top_chk #(parameter RST_TIMEOUT_CYC = 50) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Inputs watched
  input wire logic       enable,
  input wire logic       current_limit,
  input wire logic       vout_above_good,
  input wire logic       temp_hot,
  // Outputs watched
  input wire logic       high_side_on,
  input wire logic       low_side_gate_drive,
  input wire logic       regulator_en,
  input wire logic [5:0] soft_reference,
  input wire logic       reset_out_n,
  input wire logic       output_ok_flag,
  input wire logic       thermal_shutdown,
  input wire logic       soft_start_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles of good output after soft-start, for the reset delay
  int good_cnt;
  always @(posedge clk or negedge rst_n)
    if (!rst_n) good_cnt <= 0;
    else good_cnt <= (vout_above_good && soft_start_done) ? good_cnt + 1 : 0;
  property p_en_off; !enable [*3] |-> !output_ok_flag && !reset_out_n; endproperty
  a_en_off: assert property (p_en_off) else $error("flag high while disabled");
  property p_hot; temp_hot |-> ##[1:3] thermal_shutdown; endproperty
  a_hot: assert property (p_hot) else $error("no thermal shutdown");
  property p_tsd; thermal_shutdown [*2] |-> !high_side_on && !low_side_gate_drive
    && !regulator_en && !reset_out_n && !output_ok_flag; endproperty
  a_tsd: assert property (p_tsd) else $error("output active in shutdown");
  property p_ilim; $rose(current_limit) |-> ##[1:3] !high_side_on; endproperty
  a_ilim: assert property (p_ilim) else $error("switch on past limit");
  property p_rst_low; !vout_above_good [*3] |-> !reset_out_n; endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset released low vout");
  property p_ok_low; !vout_above_good [*3] |-> !output_ok_flag; endproperty
  a_ok_low: assert property (p_ok_low) else $error("ok flag with low vout");
  property p_rst_rise; $rose(reset_out_n) |-> soft_start_done
    && good_cnt >= RST_TIMEOUT_CYC - 4; endproperty
  a_rst_rise: assert property (p_rst_rise) else $error("reset released early");
  property p_ref_step; $changed(soft_reference) && soft_reference != 6'h00 |->
    soft_reference == $past(soft_reference) + 6'h01
    || soft_reference == $past(soft_reference) - 6'h01; endproperty
  a_ref_step: assert property (p_ref_step) else $error("reference jumped");
  property p_ref_hold; $changed(soft_reference) |=> $stable(soft_reference) [*8]; endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference steps too fast");
endmodule
bind bcs_top bcs_top_chk #(.RST_TIMEOUT_CYC(RST_TIMEOUT_CYC)) u_bcs_top_chk (.clk, .rst_n,
  .enable, .current_limit, .vout_above_good, .temp_hot, .high_side_on, .low_side_gate_drive,
  .regulator_en, .soft_reference, .reset_out_n, .output_ok_flag, .thermal_shutdown,
  .soft_start_done);
`default_nettype wire

// ===== test/bcs_top_tb.sv
// Testbench for the buck converter sequencer
`timescale 1ns/1ns
`default_nettype none
`include "bcs_defs.vh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module bcs_top_tb_top;
  localparam int PER = 50;
  logic clk = 0, rst_n = 0, enable = 0, sync_in = 0, overload = 0, sync_run = 0;
  logic supply_above_on = 0, supply_below_off = 1, fb_below_third = 0, vout_above_good = 0;
  logic temp_hot = 0, temp_cooled = 0;
  logic [`BCS_PER_W-1:0] freq_set_pin = 10'h032;
  logic current_limit, duty_reached, high_side_on, low_side_gate_drive, boot_refresh;
  logic regulator_en, phase_clock_out, reset_out_n, output_ok_flag, thermal_shutdown;
  logic soft_start_done;
  logic [`BCS_REF_W-1:0] soft_reference;
  int failures = 0, samples_checked = 0, scnt = 0, n, hs, pc, ls, bt;
  bcs_top #(.RST_TIMEOUT_CYC(50), .SYNC_VARIANT(1)) u_bcs_top (.clk, .rst_n, .enable,
    .sync_in, .freq_set_pin, .supply_above_on, .supply_below_off, .current_limit,
    .fb_below_third, .vout_above_good, .temp_hot, .temp_cooled, .duty_reached,
    .high_side_on, .low_side_gate_drive, .boot_refresh, .regulator_en, .soft_reference,
    .phase_clock_out, .reset_out_n, .output_ok_flag, .thermal_shutdown, .soft_start_done);
  bcs_stage_model u_bcs_stage_model (.clk, .high_side_on, .overload, .duty_reached,
    .current_limit);
  initial forever #5 clk = ~clk;
  // Sync source: 60-cycle period, 150 ns pulses
  always @(posedge clk) begin
    scnt <= (scnt == 59) ? 0 : scnt + 1;
    sync_in <= sync_run && scnt < 15;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic ref_wait(input int lim);
    logic [`BCS_REF_W-1:0] v;
    v = soft_reference;
    n = 0;
    while (soft_reference === v && n < lim) begin
      tick();
      n++;
    end
    if (n >= lim) begin
      failures++;
      end_sim();
    end
  endtask
  // Counts rises over a window that starts on a switch turn-on
  task automatic rises(input int win);
    logic h, p, q;
    h = high_side_on;
    tick();
    n = 0;
    while (!(high_side_on && !h) && n < 2000) begin
      h = high_side_on;
      tick();
      n++;
    end
    if (n >= 2000) begin
      failures++;
      end_sim();
    end
    {hs, pc, ls, bt, h, p, q} = {128'd0, high_side_on, phase_clock_out, low_side_gate_drive};
    repeat (win) begin
      tick();
      hs += int'(high_side_on && !h);
      pc += int'(phase_clock_out && !p);
      ls += int'(low_side_gate_drive && !q);
      bt += int'(boot_refresh);
      {h, p, q} = {high_side_on, phase_clock_out, low_side_gate_drive};
    end
  endtask
  task automatic t_reset;
    tick();
    `CHK("reset outs", 15'h0000, {high_side_on, low_side_gate_drive, boot_refresh,
      regulator_en, soft_reference, phase_clock_out, reset_out_n, output_ok_flag,
      thermal_shutdown, soft_start_done})
    @(posedge clk);
    rst_n <= 1;
  endtask
  task automatic t_disabled;
    @(posedge clk);
    {supply_above_on, supply_below_off, vout_above_good} <= 3'b101;
    repeat (20) tick();
    `CHK("off outs", 9'h000, {high_side_on, output_ok_flag, reset_out_n, soft_reference})
  endtask
  task automatic t_ramp;
    @(posedge clk);
    enable <= 1;
    vout_above_good <= 0;
    ref_wait(4000);
    `CHK("first step", 6'h01, soft_reference)
    ref_wait(4000);
    `CHK("step gap", 64 * PER, n)
    @(posedge clk);
    vout_above_good <= 1;
    repeat (4) tick();
    `CHK("ok flag", 1'b1, output_ok_flag)
    // Good output longer than the timeout, but soft-start still running
    repeat (60) tick();
    `CHK("reset held", 2'b00, {reset_out_n, soft_start_done})
    @(posedge clk);
    vout_above_good <= 0;
  endtask
  task automatic t_sync;
    @(posedge clk);
    sync_run <= 1;
    repeat (300) tick();
    rises(600);
    `CHK("sync turn-ons", 10, hs)
    `CHK("sync clock out", 10, pc)
    @(posedge clk);
    sync_run <= 0;
    repeat (600) tick();
    rises(10 * PER);
    `CHK("fallback turn-ons", 10, hs)
    `CHK("fallback clock out", 10, pc)
    `CHK("fallback low side", 10, ls)
    `CHK("no refresh pulses", 0, bt)
  endtask
  task automatic t_fold;
    @(posedge clk);
    overload <= 1;
    repeat (400) tick();
    rises(16 * PER);
    `CHK("folded turn-ons", 4, hs)
    @(posedge clk);
    overload <= 0;
  endtask
  task automatic t_stop;
    logic [`BCS_REF_W-1:0] v;
    // Start right after a step so no step lands near the supply drop
    ref_wait(4 * 64 * PER);
    v = soft_reference;
    @(posedge clk);
    {supply_above_on, supply_below_off} <= 2'b01;
    repeat (5) tick();
    `CHK("no drop", v, soft_reference)
    ref_wait(64 * PER + 200);
    `CHK("soft stop step", v - 6'h01, soft_reference)
    @(posedge clk);
    {supply_above_on, supply_below_off} <= 2'b10;
  endtask
  task automatic t_thermal;
    repeat (100) tick();
    @(posedge clk);
    temp_hot <= 1;
    repeat (4) tick();
    `CHK("shutdown", 11'h400, {thermal_shutdown, regulator_en, high_side_on,
      low_side_gate_drive, output_ok_flag, soft_reference})
    @(posedge clk);
    {temp_hot, temp_cooled} <= 2'b01;
    repeat (4) tick();
    `CHK("recovered", 2'b01, {thermal_shutdown, regulator_en})
  endtask
  initial begin
    t_reset();
    t_disabled();
    t_ramp();
    t_sync();
    t_fold();
    t_stop();
    t_thermal();
    end_sim();
  end
endmodule
`default_nettype wire
